/* hdl/opto_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface opto_link_if;
   // Level 1 means the photocoupler conducts
   logic forward_step_in;
   logic reverse_step_in;
   logic windings_off_in;
   logic base_angle_sel_in;
   logic alarm_out;
   logic phase_origin_out;
   modport driver (
      input forward_step_in, reverse_step_in, windings_off_in,
         base_angle_sel_in,
      output alarm_out, phase_origin_out
   );
   modport controller (
      output forward_step_in, reverse_step_in, windings_off_in,
         base_angle_sel_in,
      input alarm_out, phase_origin_out
   );
endinterface : opto_link_if
`default_nettype wire

/* hdl/opto_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module opto_sync
   import pulse_io_pkg::*;
#(
   parameter logic INIT = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Raw pin and filtered result
   input wire logic pin,
   output logic level,
   output logic rise
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } sync_state_t;
   sync_state_t st, next_st;
   always_comb
   begin
      next_st = st;
      next_st.s1 = pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.rise = 1'b0;
      // Change counts once second and third stages agree
      if (st.s2 == st.s3 && st.s3 != st.level)
      begin
         next_st.level = st.s3;
         next_st.rise = st.s3;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         st <= '{s1: INIT, s2: INIT, s3: INIT, level: INIT, rise: 1'b0};
      else
         st <= next_st;
   end
   assign level = st.level;
   assign rise = st.rise;
endmodule : opto_sync
`default_nettype wire

/* hdl/pulse_controller_end.sv */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pulse_controller_end
   import pulse_io_pkg::*;
#(
   parameter int TIM_HALF = TIM_HALF_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Opto-isolated connector
   opto_link_if.controller link
);
   typedef struct packed {
      logic [4:0] ctrl;
      logic [CNT_W-1:0] half;
      logic [CNT_W-1:0] remain;
      logic ccw;
      gen_state_t gen;
      logic [CNT_W-1:0] wait_cnt;
      logic fwd;
      logic rev;
      logic sel;
      logic [31:0] rdata;
   } ctl_state_t;
   ctl_state_t st, next_st;
   logic alarm_ok, origin_on;
   logic [CNT_W-1:0] half_eff, floor_half;
   logic acc, wr, mapped, busy, one_pulse;

   opto_sync #(.INIT(1'b1)) u_sync_alm (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin(link.alarm_out),
      .level(alarm_ok),
      .rise()
   );
   opto_sync u_sync_tim (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin(link.phase_origin_out),
      .level(origin_on),
      .rise()
   );

   always_comb
   begin
      acc = psel && penable;
      wr = acc && pwrite;
      mapped = paddr == REG_CTRL || paddr == REG_MOVE ||
         paddr == REG_HALF || paddr == REG_STATUS;
      busy = st.gen != GEN_IDLE;
      one_pulse = st.ctrl[CTRL_ONE_PULSE];
      // Fastest allowed half period for the wiring in use
      floor_half = st.ctrl[CTRL_OPEN_COLL] ? CNT_W'(OC_HALF_CYC) :
         CNT_W'(LINE_HALF_CYC);
      if (st.ctrl[CTRL_TIM_USED] && floor_half < CNT_W'(TIM_HALF))
         floor_half = CNT_W'(TIM_HALF);
      half_eff = (st.half > floor_half) ? st.half : floor_half;
   end

   always_comb
   begin
      next_st = st;
      if (psel && !penable)
      begin
         case (paddr)
            REG_CTRL: next_st.rdata = {27'h0, st.ctrl};
            REG_HALF: next_st.rdata = {8'h00, st.half};
            REG_STATUS: next_st.rdata = {st.remain, 4'h0,
               st.sel != st.ctrl[CTRL_BASE_SEL], origin_on,
               !alarm_ok, busy};
            default: next_st.rdata = 32'h00000000;
         endcase
      end
      if (wr && paddr == REG_CTRL)
      begin
         next_st.ctrl = pwdata[4:0];
         // Mode is frozen during a move
         if (busy)
            next_st.ctrl[CTRL_ONE_PULSE] = st.ctrl[CTRL_ONE_PULSE];
      end
      if (wr && paddr == REG_HALF)
         next_st.half = pwdata[CNT_W-1:0];
      // Apply base-angle select only at rest and at origin
      if (!busy && origin_on)
         next_st.sel = st.ctrl[CTRL_BASE_SEL];
      case (st.gen)
         GEN_IDLE:
         begin
            next_st.fwd = 1'b0;
            next_st.rev = 1'b0;
            if (wr && paddr == REG_MOVE && pwdata[CNT_W-1:0] != '0 &&
               alarm_ok)
            begin
               next_st.remain = pwdata[CNT_W-1:0];
               next_st.ccw = pwdata[MOVE_CCW];
               next_st.rev = one_pulse && !pwdata[MOVE_CCW];
               next_st.wait_cnt = '0;
               next_st.gen = GEN_SETUP;
            end
         end
         GEN_SETUP, GEN_HIGH, GEN_LOW:
         begin
            next_st.wait_cnt = st.wait_cnt + 24'h000001;
            if (!alarm_ok)
            begin
               next_st.gen = GEN_IDLE;
               next_st.remain = '0;
               next_st.fwd = 1'b0;
               next_st.rev = 1'b0;
            end
            else if (st.wait_cnt >= half_eff - 24'h000001)
            begin
               next_st.wait_cnt = '0;
               if (st.gen == GEN_HIGH)
               begin
                  next_st.fwd = 1'b0;
                  if (!one_pulse)
                     next_st.rev = 1'b0;
                  next_st.remain = st.remain - 24'h000001;
                  next_st.gen = GEN_LOW;
               end
               else if (st.gen == GEN_LOW && st.remain == '0)
               begin
                  next_st.rev = 1'b0;
                  next_st.gen = GEN_IDLE;
               end
               else
               begin
                  // Two-pulse: one line only; one-pulse: forward pulses while reverse holds direction
                  next_st.fwd = one_pulse || !st.ccw;
                  if (!one_pulse)
                     next_st.rev = st.ccw;
                  next_st.gen = GEN_HIGH;
               end
            end
         end
         default: next_st.gen = GEN_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st.ctrl <= CTRL_RESET;
         st.half <= HALF_RESET;
         st.remain <= '0;
         st.ccw <= 1'b0;
         st.gen <= GEN_IDLE;
         st.wait_cnt <= '0;
         st.fwd <= 1'b0;
         st.rev <= 1'b0;
         st.sel <= 1'b0;
         st.rdata <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign prdata = st.rdata;
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   assign link.forward_step_in = st.fwd;
   assign link.reverse_step_in = st.rev;
   assign link.windings_off_in = st.ctrl[CTRL_WINDINGS_OFF];
   assign link.base_angle_sel_in = st.sel;
endmodule : pulse_controller_end
`default_nettype wire

/* hdl/pulse_io_pkg.sv */
// Functional notes
// - Two-pulse forward edge steps once clockwise
// - Two-pulse reverse edge steps once counter-clockwise
// - Controller never drives both step lines in two-pulse mode
// - Pulse lines stay OFF while at rest
// - One-pulse edge, direction ON: clockwise step
// - One-pulse edge, direction OFF: counter-clockwise step
// - Input mode selects meaning of line pair
// - Pulse rate limited by output driver type
// - Windings-off ON cuts motor current
// - Windings-off OFF restores motor current
// - Base-angle select picks base or resolution step
// - Base-angle select unchanged while moving
// - Base-angle select changes only at origin
// - Alarm output conducts normally, opens on alarm
// - Indicator blinks red on alarm, else green
// - Excitation returns to step zero each period
// - Step angle is base angle over resolution
// - Timing use keeps pulse rate under 500 Hz
// - Moves end at whole origin periods (controller stops after the written step count, at or off origin)
// - Level one means photocoupler conducting
package pulse_io_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int LINE_MAX_HZ = 1_000_000;
   localparam int OC_MAX_HZ = 250_000;
   localparam int TIM_MAX_HZ = 500;
   // Least half periods, rounded up to whole cycles
   localparam int LINE_HALF_CYC = (CLK_HZ + 2 * LINE_MAX_HZ - 1) /
      (2 * LINE_MAX_HZ);
   localparam int OC_HALF_CYC = (CLK_HZ + 2 * OC_MAX_HZ - 1) /
      (2 * OC_MAX_HZ);
   localparam int TIM_HALF_CYC = (CLK_HZ + 2 * TIM_MAX_HZ - 1) /
      (2 * TIM_MAX_HZ);
   localparam int BLINK_MS = 250;
   localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_MS;
   // Position unit: base step / 2520, so every resolution 1..10 divides
   localparam int MICRO_UNITS = 2520;
   localparam int RES_MIN = 1;
   localparam int RES_MAX = 10;
   localparam int STEPS_ORIGIN_18 = 4;
   localparam int STEPS_ORIGIN_072 = 10;
   localparam int STEPS_ORIGIN_036 = 10;
   localparam int POS_W = 15;
   localparam int CNT_W = 24;
   localparam logic [1:0] MOTOR_18 = 2'h0;
   localparam logic [1:0] MOTOR_072 = 2'h1;
   localparam logic [1:0] MOTOR_036 = 2'h2;
   // Controller register map
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_MOVE = 12'h004;
   localparam logic [11:0] REG_HALF = 12'h008;
   localparam logic [11:0] REG_STATUS = 12'h00c;
   localparam int CTRL_ONE_PULSE = 0;
   localparam int CTRL_WINDINGS_OFF = 1;
   localparam int CTRL_BASE_SEL = 2;
   localparam int CTRL_OPEN_COLL = 3;
   localparam int CTRL_TIM_USED = 4;
   localparam int MOVE_CCW = 31;
   localparam int ST_BUSY = 0;
   localparam int ST_ALARM = 1;
   localparam int ST_ORIGIN = 2;
   localparam int ST_SEL_PEND = 3;
   localparam int ST_REMAIN_LSB = 8;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [CNT_W-1:0] HALF_RESET = 24'h000064;
   typedef enum logic {TWO_PULSE, ONE_PULSE} pulse_mode_t;
   typedef enum logic [1:0] {GEN_IDLE, GEN_SETUP, GEN_HIGH, GEN_LOW}
      gen_state_t;
   function automatic logic [POS_W-1:0] step_units(input logic [3:0] res);
      int r;
      r = (res < RES_MIN || res > RES_MAX) ? RES_MIN : int'(res);
      return POS_W'(MICRO_UNITS / r);
   endfunction : step_units
   function automatic logic [POS_W-1:0] origin_span(input logic [1:0] mt);
      case (mt)
         MOTOR_072: return POS_W'(STEPS_ORIGIN_072 * MICRO_UNITS);
         MOTOR_036: return POS_W'(STEPS_ORIGIN_036 * MICRO_UNITS);
         default: return POS_W'(STEPS_ORIGIN_18 * MICRO_UNITS);
      endcase
   endfunction : origin_span
endpackage : pulse_io_pkg

/* hdl/stepper_driver_end.sv */
`timescale 1ns/1ps
`default_nettype none
module stepper_driver_end
   import pulse_io_pkg::*;
#(
   parameter int BLINK_CYC = BLINK_HALF_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Opto-isolated connector
   opto_link_if.driver link,
   // Driver configuration switches
   input wire logic one_pulse_mode,
   input wire logic [3:0] resolution,
   input wire logic [1:0] motor_type,
   // Fault detection from the power stage
   input wire logic fault_in,
   // Power stage and indicator
   output logic [POS_W-1:0] excitation_pos,
   output logic current_on,
   output logic led_green,
   output logic led_red
);
   typedef struct packed {
      logic [POS_W-1:0] pos;
      logic origin;
      logic alarm;
      logic current;
      logic [22:0] blink_cnt;
      logic blink;
   } drv_state_t;
   drv_state_t st, next_st;

   logic fwd_level, fwd_rise;
   logic rev_level, rev_rise;
   logic awo_level;
   logic sel_level;

   // Input conditioning for the four opto inputs
   opto_sync u_sync_fwd (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin(link.forward_step_in),
      .level(fwd_level),
      .rise(fwd_rise)
   );
   opto_sync u_sync_rev (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin(link.reverse_step_in),
      .level(rev_level),
      .rise(rev_rise)
   );
   opto_sync u_sync_awo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin(link.windings_off_in),
      .level(awo_level),
      .rise()
   );
   opto_sync u_sync_sel (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin(link.base_angle_sel_in),
      .level(sel_level),
      .rise()
   );

   logic step_pulse_in;
   logic step_cw;
   logic step_ccw;
   logic [POS_W-1:0] inc;
   logic [POS_W-1:0] span;
   logic [POS_W:0] up_sum;
   logic [POS_W:0] down_sum;

   always_comb
   begin
      step_pulse_in = fwd_rise;
      step_cw = 1'b0;
      step_ccw = 1'b0;
      // Line pair meaning follows the configured mode
      if (pulse_mode_t'(one_pulse_mode) == ONE_PULSE)
      begin
         step_cw = step_pulse_in && rev_level;
         step_ccw = step_pulse_in && !rev_level;
      end
      else
      begin
         // A rise while the other line is still ON is abnormal input.
         // It is dropped rather than guessed at, and this covers
         // simultaneous rises as well.
         step_cw = fwd_rise && !rev_level;
         step_ccw = rev_rise && !fwd_level;
      end
   end

   always_comb
   begin
      // Base step or resolution step per pulse
      inc = sel_level ? POS_W'(MICRO_UNITS) : step_units(resolution);
      span = origin_span(motor_type);
      up_sum = {1'b0, st.pos} + {1'b0, inc};
      down_sum = {1'b0, st.pos} + {1'b0, span} - {1'b0, inc};
   end

   always_comb
   begin
      next_st = st;
      // Alarm latches until reset
      if (fault_in)
      begin
         next_st.alarm = 1'b1;
      end
      // Current off on alarm or windings-off
      next_st.current = !next_st.alarm && !awo_level;
      // Steps only move a powered excitation
      if (st.current && step_cw)
      begin
         if (up_sum >= {1'b0, span})
            next_st.pos = POS_W'(up_sum - {1'b0, span});
         else
            next_st.pos = up_sum[POS_W-1:0];
      end
      else if (st.current && step_ccw)
      begin
         if (st.pos >= inc)
            next_st.pos = st.pos - inc;
         else
            next_st.pos = down_sum[POS_W-1:0];
      end
      next_st.origin = (next_st.pos == '0);
      // Red blink timebase
      if (st.alarm)
      begin
         if (st.blink_cnt == 23'(BLINK_CYC - 1))
         begin
            next_st.blink_cnt = '0;
            next_st.blink = !st.blink;
         end
         else
         begin
            next_st.blink_cnt = st.blink_cnt + 23'h000001;
         end
      end
      else
      begin
         next_st.blink_cnt = '0;
         next_st.blink = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st.pos <= '0;
         st.origin <= 1'b1;
         st.alarm <= 1'b0;
         st.current <= 1'b0;
         st.blink_cnt <= '0;
         st.blink <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs, 1 means conducting
   assign link.alarm_out = !st.alarm;
   assign link.phase_origin_out = st.origin;
   assign excitation_pos = st.pos;
   assign current_on = st.current;
   assign led_green = !st.alarm;
   assign led_red = st.alarm && st.blink;
endmodule : stepper_driver_end
`default_nettype wire

/* test/pulse_io_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_io_props
   import pulse_io_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Connector lines
   input wire logic forward_step_in,
   input wire logic reverse_step_in,
   input wire logic windings_off_in,
   input wire logic base_angle_sel_in,
   input wire logic alarm_out,
   input wire logic phase_origin_out,
   // Driver side
   input wire logic one_pulse_mode,
   input wire logic current_on,
   input wire logic [POS_W-1:0] excitation_pos
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   step_lines_apart_a:
      assert property (!one_pulse_mode |-> !(forward_step_in && reverse_step_in))
      else $error("Both step lines on");
   pulse_width_a:
      assert property ($rose(forward_step_in) |->
         forward_step_in[*8] ##1 forward_step_in[*5])
      else $error("Step pulse too short");
   alarm_cuts_a:
      assert property (!alarm_out |-> ##[0:1] !current_on)
      else $error("Current kept on alarm");
   alarm_latch_a:
      assert property ($fell(alarm_out) |=> !alarm_out[*8])
      else $error("Alarm did not hold");
   windings_cut_a:
      assert property (windings_off_in[*6] |-> !current_on)
      else $error("Current kept with windings off");
   windings_restore_a:
      assert property ((!windings_off_in && alarm_out)[*6] |-> current_on)
      else $error("Current not restored");
   forward_step_a:
      assert property ($rose(forward_step_in) && current_on |->
         ##[3:7] $changed(excitation_pos))
      else $error("Step pulse not taken");
   reverse_step_a:
      assert property ($rose(reverse_step_in) && current_on && !one_pulse_mode
         |-> ##[3:7] $changed(excitation_pos))
      else $error("Reverse pulse not taken");
   step_once_a:
      assert property ($changed(excitation_pos) |=> $stable(excitation_pos)[*8])
      else $error("Step counted twice");
   origin_flag_a:
      assert property ($changed(excitation_pos) |->
         ##[0:1] (phase_origin_out == (excitation_pos == '0)))
      else $error("Origin output wrong");
   base_at_origin_a:
      assert property ($changed(base_angle_sel_in) |-> phase_origin_out)
      else $error("Base select changed off origin");
endmodule : pulse_io_props
`default_nettype wire

/* test/test_stepper_pulse_io_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_stepper_pulse_io_control
   import pulse_io_pkg::*;
();
   typedef struct {
      logic [4:0] ctrl;
      logic ccw;
      logic [23:0] cnt;
      logic [3:0] res;
      logic [POS_W-1:0] pos;
   } row_t;
   logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic one_pulse_mode, fault_in, current_on, led_green, led_red;
   logic [3:0] resolution;
   logic [1:0] motor_type;
   logic [POS_W-1:0] excitation_pos;
   localparam int TIM_HALF_TB = 20;
   int errors, checks_done, n;
   row_t rows [8];
   opto_link_if link ();
   pulse_controller_end #(.TIM_HALF(TIM_HALF_TB)) i_pulse_controller_end (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link.controller));
   stepper_driver_end #(.BLINK_CYC(8)) i_stepper_driver_end (
      .ref_clk(ref_clk), .reset_n(reset_n), .link(link.driver),
      .one_pulse_mode(one_pulse_mode), .resolution(resolution),
      .motor_type(motor_type), .fault_in(fault_in),
      .excitation_pos(excitation_pos), .current_on(current_on),
      .led_green(led_green), .led_red(led_red));
   pulse_io_props i_pulse_io_props (
      .ref_clk(ref_clk), .reset_n(reset_n),
      .forward_step_in(link.forward_step_in),
      .reverse_step_in(link.reverse_step_in),
      .windings_off_in(link.windings_off_in),
      .base_angle_sel_in(link.base_angle_sel_in),
      .alarm_out(link.alarm_out), .phase_origin_out(link.phase_origin_out),
      .one_pulse_mode(one_pulse_mode), .current_on(current_on),
      .excitation_pos(excitation_pos));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic check(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Access phase lasts until pready is seen high at an edge
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic run_move(input logic ccw, input logic [23:0] cnt);
      int k;
      apb(1'b1, REG_MOVE, {ccw, 7'h00, cnt});
      rd = 32'h1;
      for (k = 0; k < 2000 && rd[ST_BUSY] === 1'b1; k++)
         apb(1'b0, REG_STATUS, 32'h0);
      check("move done", 1'b0, rd[ST_BUSY]);
      repeat (10) @(posedge ref_clk);
   endtask : run_move
   // One clockwise step; the step line's high time is counted
   task automatic pulse_width(input logic [4:0] c, input int exp);
      int w;
      apb(1'b1, REG_CTRL, {27'h0, c});
      apb(1'b1, REG_MOVE, 32'h00000001);
      w = 0;
      wait (link.forward_step_in === 1'b1);
      @(negedge ref_clk);
      while (link.forward_step_in === 1'b1)
      begin
         w++;
         @(negedge ref_clk);
      end
      check("pulse width", exp, w);
      repeat (2 * exp) @(posedge ref_clk);
   endtask : pulse_width
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      give_verdict();
   end
   initial
   begin
      rows[0] = '{5'h00, 1'h0, 24'h000003, 4'h1, 15'h1d88};
      rows[1] = '{5'h00, 1'h1, 24'h000002, 4'h5, 15'h1998};
      rows[2] = '{5'h01, 1'h0, 24'h000004, 4'ha, 15'h1d88};
      rows[3] = '{5'h01, 1'h1, 24'h000003, 4'h1, 15'h0000};
      rows[4] = '{5'h04, 1'h0, 24'h000001, 4'ha, 15'h09d8};
      rows[5] = '{5'h04, 1'h1, 24'h000001, 4'ha, 15'h0000};
      rows[6] = '{5'h00, 1'h0, 24'h000001, 4'hf, 15'h09d8};
      rows[7] = '{5'h00, 1'h1, 24'h000001, 4'h0, 15'h0000};
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      one_pulse_mode = 1'b0;
      resolution = 4'h1;
      motor_type = MOTOR_18;
      fault_in = 1'b0;
      errors = 0;
      checks_done = 0;
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      apb(1'b1, REG_HALF, 32'h5);
      apb(1'b0, REG_HALF, 32'h0);
      check("half", 32'h5, rd);
      foreach (rows[i])
      begin
         one_pulse_mode <= rows[i].ctrl[CTRL_ONE_PULSE];
         resolution <= rows[i].res;
         apb(1'b1, REG_CTRL, {27'h0, rows[i].ctrl});
         repeat (12) @(posedge ref_clk);
         run_move(rows[i].ccw, rows[i].cnt);
         check("position", rows[i].pos, excitation_pos);
         check("origin", rows[i].pos == '0, link.phase_origin_out);
      end
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped error", 1'b1, err);
      check("unmapped data", 32'h0, rd);
      apb(1'b1, REG_CTRL, 32'h2);
      repeat (8) @(posedge ref_clk);
      check("current off", 1'b0, current_on);
      run_move(1'b0, 24'h000001);
      check("held position", 15'h0000, excitation_pos);
      apb(1'b1, REG_CTRL, 32'h0);
      repeat (8) @(posedge ref_clk);
      check("current on", 1'b1, current_on);
      pulse_width(5'h00, LINE_HALF_CYC);
      pulse_width(5'h08, OC_HALF_CYC);
      pulse_width(5'h10, TIM_HALF_TB);
      check("width moves", 15'h1d88, excitation_pos);
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl", 32'h10, rd);
      fault_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      fault_in <= 1'b0;
      check("alarm", 1'b0, link.alarm_out);
      check("alarm current", 1'b0, current_on);
      check("green", 1'b0, led_green);
      n = 0;
      repeat (20)
      begin
         @(posedge ref_clk);
         if (led_red === 1'b1)
            n++;
      end
      check("red blink", 1'b1, n > 0 && n < 20);
      check("alarm held", 1'b0, link.alarm_out);
      apb(1'b0, REG_STATUS, 32'h0);
      check("status alarm", 1'b1, rd[ST_ALARM]);
      reset_n <= 1'b0;
      repeat (10) @(posedge ref_clk);
      check("reset alarm", 1'b1, link.alarm_out);
      check("reset origin", 1'b1, link.phase_origin_out);
      check("reset green", 1'b1, led_green);
      motor_type <= MOTOR_072;
      resolution <= 4'h1;
      reset_n <= 1'b1;
      run_move(1'b0, 24'h000009);
      check("origin off", 1'b0, link.phase_origin_out);
      run_move(1'b0, 24'h000001);
      check("wide period", 15'h0000, excitation_pos);
      check("origin back", 1'b1, link.phase_origin_out);
      give_verdict();
   end
endmodule : test_stepper_pulse_io_control
`default_nettype wire
